// ===== verilog/fep_flash_protect.v
// flash array with erase/program/read access checks
// assumes one request at a time, held until done_out pulses
`timescale 1ns/1ps
`include "fep_defs.vh"
module fep_flash_protect (
   input  wire                     clk_in,
   input  wire                     srst_in,
   input  wire                     req_in,
   input  wire [2:0]               op_in,
   input  wire [`FEP_ADDR_W-1:0]   addr_in,
   input  wire [31:0]              wdata_in,
   input  wire                     set_we_in,
   input  wire [`FEP_REGION_W-1:0] set_region_in,
   input  wire                     set_ro_in,
   input  wire                     set_xo_in,
   output reg                      done_out,
   output reg                      denied_out,
   output reg  [31:0]              rdata_out,
   output reg                      busy_out
);

   // ============================================================
   // state codes
   localparam ST_IDLE  = 2'h0;
   localparam ST_ERASE = 2'h1;

   // ============================================================
   // flash array and registered state
   reg  [31:0]              mem [0:(1<<`FEP_WORD_W)-1];
   reg  [1:0]               state;
   reg  [7:0]               ecnt;
   reg  [7:0]               eunit;

   // ============================================================
   // next values
   reg  [1:0]               next_state;
   reg  [7:0]               next_ecnt;
   reg  [7:0]               next_eunit;
   reg                      next_done;
   reg                      next_denied;
   reg  [31:0]              next_rdata;
   reg                      next_busy;

   // ============================================================
   // array port controls
   reg                      mem_we;
   reg                      mem_and;
   reg                      mem_re;
   reg  [`FEP_WORD_W-1:0]   mem_waddr;
   reg  [31:0]              mem_wdata;

   // ============================================================
   // protection lookup
   wire [`FEP_REGION_W-1:0] region;
   wire                     ro;
   wire                     xo;

   assign region = addr_in[`FEP_ADDR_W-1:`FEP_REGION_LSB];

   fep_prot_table u_tab (
      .clk_in         (clk_in),
      .srst_in        (srst_in),
      .set_we_in      (set_we_in),
      .set_region_in  (set_region_in),
      .set_ro_in      (set_ro_in),
      .set_xo_in      (set_xo_in),
      .look_region_in (region),
      .look_ro_out    (ro),
      .look_xo_out    (xo)
   );

   // ============================================================
   // request decode
   wire [`FEP_WORD_W-1:0]   widx;
   wire [7:0]               unit;
   wire                     op_fetch;
   wire                     op_dread;
   wire                     op_dbg;
   wire                     op_prog;
   wire                     op_erase;
   wire                     is_write;
   wire                     is_read;
   wire                     take;

   assign widx     = addr_in[`FEP_ADDR_W-1:`FEP_WORD_LSB];
   assign unit     = addr_in[`FEP_ADDR_W-1:`FEP_UNIT_LSB];
   assign op_fetch = (op_in == `FEP_OP_FETCH);
   assign op_dread = (op_in == `FEP_OP_DREAD);
   assign op_dbg   = (op_in == `FEP_OP_DBGREAD);
   assign op_prog  = (op_in == `FEP_OP_PROGRAM);
   assign op_erase = (op_in == `FEP_OP_ERASE);
   assign is_write = op_prog || op_erase;
   assign is_read  = op_fetch || op_dread || op_dbg;
   // the done cycle blocks a second take of a held request
   assign take     = (state == ST_IDLE) && req_in && !done_out;

   // ============================================================
   // permission check
   wire                     deny_ro;
   wire                     deny_xo_wr;
   wire                     deny_xo_rd;
   wire                     deny_bad;
   wire                     deny;

   assign deny_ro    = is_write && ro;
   assign deny_xo_wr = is_write && xo;
   assign deny_xo_rd = xo && (op_dread || op_dbg);
   // unknown request codes are refused
   assign deny_bad   = !is_write && !is_read;
   assign deny       = deny_ro || deny_xo_wr || deny_xo_rd || deny_bad;

   // ============================================================
   // erase sequencer
   wire                     erase_last;
   wire [`FEP_WORD_W-1:0]   erase_addr;

   assign erase_last = ({1'b0, ecnt} == (`FEP_UNIT_WORDS - 9'h001));
   assign erase_addr = {eunit, ecnt};

   // ============================================================
   // next-state logic
   always @* begin
      next_state  = state;
      next_ecnt   = ecnt;
      next_eunit  = eunit;
      next_done   = 1'b0;
      next_denied = denied_out;
      next_rdata  = rdata_out;
      next_busy   = busy_out;
      mem_we      = 1'b0;
      mem_and     = 1'b0;
      mem_re      = 1'b0;
      mem_waddr   = widx;
      mem_wdata   = wdata_in;
      case (state)
         ST_IDLE: begin
            if (take) begin
               if (deny) begin
                  next_done   = 1'b1;
                  next_denied = 1'b1;
                  next_rdata  = 32'h00000000;
               end else if (op_erase) begin
                  // erase a single 1 KB unit
                  next_eunit = unit;
                  next_ecnt  = 8'h00;
                  next_busy  = 1'b1;
                  next_state = ST_ERASE;
               end else if (op_prog) begin
                  // programming can only clear bits
                  mem_we      = 1'b1;
                  mem_and     = 1'b1;
                  next_done   = 1'b1;
                  next_denied = 1'b0;
               end else begin
                  mem_re      = 1'b1;
                  next_done   = 1'b1;
                  next_denied = 1'b0;
               end
            end
         end
         ST_ERASE: begin
            mem_we    = 1'b1;
            mem_waddr = erase_addr;
            mem_wdata = `FEP_ERASED_WORD;
            next_ecnt = ecnt + 8'h01;
            if (erase_last) begin
               next_busy   = 1'b0;
               next_done   = 1'b1;
               next_denied = 1'b0;
               next_state  = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_busy  = 1'b0;
         end
      endcase
   end

   // ============================================================
   // state and output registers
   always @(posedge clk_in) begin
      if (srst_in) begin
         state      <= ST_IDLE;
         ecnt       <= 8'h00;
         eunit      <= 8'h00;
         done_out   <= 1'b0;
         denied_out <= 1'b0;
         rdata_out  <= 32'h00000000;
         busy_out   <= 1'b0;
      end else begin
         state      <= next_state;
         ecnt       <= next_ecnt;
         eunit      <= next_eunit;
         done_out   <= next_done;
         denied_out <= next_denied;
         busy_out   <= next_busy;
         // read data is taken from the array in the take cycle and registered with done_out
         if (mem_re)
            rdata_out <= mem[widx];
         else
            rdata_out <= next_rdata;
      end
   end

   // ============================================================
   // flash array write port
   always @(posedge clk_in) begin
      if (!srst_in && mem_we) begin
         if (mem_and)
            mem[mem_waddr] <= mem[mem_waddr] & mem_wdata;
         else
            mem[mem_waddr] <= mem_wdata;
      end
   end

endmodule // fep_flash_protect

// ===== inc/fep_defs.vh
// constants for the flash erase/protect access checker
// assumes byte addressing over the whole flash array
`ifndef FEP_DEFS_VH
`define FEP_DEFS_VH
// ============================================================
// geometry
`define FEP_ADDR_W      18
`define FEP_UNIT_LSB    10
`define FEP_REGION_LSB  11
`define FEP_NUM_REGIONS 128
`define FEP_REGION_W    7
`define FEP_WORD_LSB    2
`define FEP_WORD_W      16
// ============================================================
// request codes
`define FEP_OP_FETCH    3'h0
`define FEP_OP_DREAD    3'h1
`define FEP_OP_DBGREAD  3'h2
`define FEP_OP_PROGRAM  3'h3
`define FEP_OP_ERASE    3'h4
// ============================================================
// erased word value and erase timing
`define FEP_ERASED_WORD 32'hffffffff
`define FEP_UNIT_WORDS  9'h100
`endif

// ===== verilog/fep_prot_table.v
// per-region protection table with one generate entry per region
// assumes setting writes come from trusted logic on clk_in
`timescale 1ns/1ps
`include "fep_defs.vh"
module fep_prot_table (
   input  wire                     clk_in,
   input  wire                     srst_in,
   input  wire                     set_we_in,
   input  wire [`FEP_REGION_W-1:0] set_region_in,
   input  wire                     set_ro_in,
   input  wire                     set_xo_in,
   input  wire [`FEP_REGION_W-1:0] look_region_in,
   output wire                     look_ro_out,
   output wire                     look_xo_out
);
   wire [`FEP_NUM_REGIONS-1:0] ro_bits;
   wire [`FEP_NUM_REGIONS-1:0] xo_bits;
   genvar g;
   generate
      for (g = 0; g < `FEP_NUM_REGIONS; g = g + 1) begin : g_reg
         reg ro;
         reg xo;
         always @(posedge clk_in) begin
            if (srst_in) begin
               ro <= 1'b0;
               xo <= 1'b0;
            end else if (set_we_in && set_region_in == g) begin
               ro <= set_ro_in;
               xo <= set_xo_in;
            end
         end
         assign ro_bits[g] = ro;
         assign xo_bits[g] = xo;
      end
   endgenerate
   assign look_ro_out = ro_bits[look_region_in];
   assign look_xo_out = xo_bits[look_region_in];
endmodule // fep_prot_table

// ===== dv/fep_req_model.sv
// requester model: fetch, data and debugger paths
// assumes done_in is the block's one-cycle done pulse
`timescale 1ns/1ps
module fep_req_model (
   input  wire        clk_in,
   input  wire        go_in,
   input  wire [52:0] cmd_in,
   input  wire        done_in,
   output reg         req_out = 1'b0,
   output reg  [52:0] cmd_out = 53'h0
);
   // holds the request until done, then scrambles the released lines
   always @(posedge clk_in) begin
      if (go_in && !req_out) {req_out, cmd_out} <= {1'b1, cmd_in};
      else if (done_in) {req_out, cmd_out} <= {1'b0, ~cmd_out};
   end
endmodule // fep_req_model

// ===== dv/fep_props_properties.sv
// checker on the ports of fep_flash_protect
// assumes one clock domain with synchronous reset
`timescale 1ns/1ps
module fep_props (
   input wire        clk_in,
   input wire        srst_in,
   input wire        req_in,
   input wire [2:0]  op_in,
   input wire [17:0] addr_in,
   input wire        set_we_in,
   input wire [6:0]  set_region_in,
   input wire        set_ro_in,
   input wire        set_xo_in,
   input wire        done_out,
   input wire        denied_out,
   input wire [31:0] rdata_out,
   input wire        busy_out
);
   reg  [127:0] ro = 128'h0;
   reg  [127:0] xo = 128'h0;
   wire [6:0]   rg = addr_in[17:11];
   wire         tk = req_in && !busy_out && !done_out;
   wire         fr = !ro[rg] && !xo[rg];
   always @(posedge clk_in) begin
      if (srst_in) {ro, xo} <= 256'h0;
      else if (set_we_in) {ro[set_region_in], xo[set_region_in]} <= {set_ro_in, set_xo_in};
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);
   a_ro_refuse: assert property (tk && ro[rg] && op_in > 3'h2 |=> done_out && denied_out) else $error("ro");
   a_xo_refuse: assert property (tk && xo[rg] && op_in > 3'h2 |=> done_out && denied_out) else $error("xo");
   a_xo_read: assert property (tk && xo[rg] && op_in inside {3'h1, 3'h2} |=> denied_out) else $error("xr");
   a_fetch_ok: assert property (tk && op_in == 3'h0 |=> done_out && !denied_out) else $error("fetch");
   a_open_ok: assert property (tk && fr && op_in inside {[3'h1:3'h3]} |=> !denied_out) else $error("open");
   a_erase_time: assert property (tk && fr && op_in == 3'h4 |=> busy_out ##256 done_out) else $error("erase");
   a_done_pulse: assert property (done_out |=> !done_out) else $error("done");
   a_deny_zero: assert property (denied_out |-> rdata_out == 32'h0) else $error("rdata");
   c_erase: cover property (tk && op_in == 3'h4);
   c_deny: cover property (done_out && denied_out);
   c_xo_fetch: cover property (tk && xo[rg] && op_in == 3'h0);
endmodule // fep_props
bind fep_flash_protect fep_props u_props (.*);

// ===== dv/fep_flash_protect_tb_top.sv
// bench for fep_flash_protect driven through the requester model
// assumes a free-running 10 MHz clock
`timescale 1ns/1ps
module fep_flash_protect_tb_top;
   localparam [32:0] DN = 33'h100000000, FF = 33'hffffffff, V = 33'h5a5a000f;
   reg         clk_in = 0, srst_in = 1, go = 0, swe = 0, sro = 0, sxo = 0;
   reg  [6:0]  srg = 0;
   reg  [52:0] cmd = 0;
   wire [52:0] mc;
   wire        req, done_out, denied_out, busy_out;
   wire [31:0] rdata_out;
   integer     err_total = 0, samples_checked = 0, cyc = 0;
   always #50 clk_in = ~clk_in;
   fep_req_model u_req (.clk_in(clk_in), .go_in(go), .cmd_in(cmd), .done_in(done_out), .req_out(req), .cmd_out(mc));
   fep_flash_protect uut (.clk_in(clk_in), .srst_in(srst_in), .req_in(req), .op_in(mc[52:50]), .addr_in(mc[49:32]),
      .wdata_in(mc[31:0]), .set_we_in(swe), .set_region_in(srg), .set_ro_in(sro), .set_xo_in(sxo),
      .done_out(done_out), .denied_out(denied_out), .rdata_out(rdata_out), .busy_out(busy_out));
   task check(input [32:0] s, input [32:0] e);
      begin
         samples_checked = samples_checked + 1;
         if (s !== e) begin
            err_total = err_total + 1;
            $display("ERROR deny_rdata exp %h seen %h", e, s);
         end
      end
   endtask
   task test_done;
      begin
         $display("checks %0d mismatches %0d", samples_checked, err_total);
         if (err_total == 0 && samples_checked > 0) $display("Test passed");
         else $display("Test failed");
         $finish;
      end
   endtask
   // one request; writes compare only the refusal flag
   task run(input [2:0] o, input [17:0] a, input [31:0] d, input [32:0] e);
      begin
         cmd <= {o, a, d};
         go <= 1'b1;
         @(posedge clk_in) go <= 1'b0;
         // a lost answer is caught by the cycle ceiling
         while (done_out !== 1'b1) @(posedge clk_in);
         check({denied_out, o > 3'h2 ? 32'h0 : rdata_out}, e);
      end
   endtask
   task prot(input [6:0] r, input ro, input xo);
      begin
         {srg, sro, sxo, swe} <= {r, ro, xo, 1'b1};
         @(posedge clk_in) swe <= 1'b0;
      end
   endtask
   task t_open;
      begin
         run(3'h4, 18'h400, 0, 0);
         run(3'h1, 18'h7fc, 0, FF);
         run(3'h3, 18'h400, 32'h5a5a00ff, 0);
         run(3'h3, 18'h400, 32'hffff0f0f, 0);
         run(3'h4, 18'h0, 0, 0);
         run(3'h2, 18'h400, 0, V);
         run(3'h4, 18'h3fc00, 0, 0);
         run(3'h0, 18'h3fffc, 0, FF);
         $display("t_open done");
      end
   endtask
   task t_prot;
      begin
         prot(7'h0, 1'b1, 1'b0);
         run(3'h3, 18'h400, 0, DN);
         run(3'h4, 18'h0, 0, DN);
         run(3'h1, 18'h400, 0, V);
         prot(7'h0, 1'b0, 1'b1);
         run(3'h0, 18'h400, 0, V);
         run(3'h1, 18'h400, 0, DN);
         run(3'h2, 18'h7fc, 0, DN);
         run(3'h1, 18'h3fffc, 0, FF);
         run(3'h3, 18'h400, 0, DN);
         run(3'h4, 18'h400, 0, DN);
         prot(7'h0, 1'b0, 1'b0);
         run(3'h1, 18'h400, 0, V);
         run(3'h7, 18'h400, 0, DN);
         $display("t_prot done");
      end
   endtask
   always @(posedge clk_in) begin
      cyc = cyc + 1;
      if (cyc > 3000) begin
         err_total = err_total + 1;
         test_done;
      end
   end
   initial begin
      repeat (4) @(posedge clk_in);
      srst_in <= 1'b0;
      t_open;
      t_prot;
      test_done;
   end
endmodule // fep_flash_protect_tb_top
